// ===== pkg/mac_pkg.sv
// mac_pkg: constants, fields and carrier types of the multiply block
// assumes a 24-bit instruction word, 16-bit working registers, 40-bit accumulators
`default_nettype none

package mac_pkg;

    // datapath widths
    localparam int INSTR_W = 24;
    localparam int WORD_W = 16;
    localparam int ACC_W = 40;
    localparam int PROD_W = 32;

    // two-register multiply opcode: 1100 0mmm A0xx yyii iijj jj11
    localparam logic [4:0] MUL_PREFIX = 5'h18;
    localparam int MUL_PREFIX_LSB = 19;
    localparam int MUL_PAIR_LSB = 16;
    localparam logic [1:0] MUL_SUFFIX = 2'h3;
    // square opcode: 1111 00mm A0xx yyii iijj jj01
    localparam logic [5:0] SQR_PREFIX = 6'h3c;
    localparam int SQR_PREFIX_LSB = 18;
    localparam int SQR_REG_LSB = 16;
    localparam logic [1:0] SQR_SUFFIX = 2'h1;
    // fields common to both forms
    localparam int ACC_SEL_BIT = 15;
    localparam int ZERO_BIT = 14;
    localparam int XD_LSB = 12;
    localparam int YD_LSB = 10;
    localparam int XOP_LSB = 6;
    localparam int YOP_LSB = 2;

    // prefetch operation codes of the i and j fields
    localparam logic [3:0] PF_NONE = 4'h4;
    localparam logic [3:0] PF_REG_OFFSET = 4'hc;

    // register numbers of the working register file
    localparam logic [3:0] WREG_BASE = 4'h4;
    localparam logic [3:0] XPTR_BASE = 4'h8;
    localparam logic [3:0] YPTR_BASE = 4'ha;

    // core_control_register fields
    localparam int CTRL_INT_MODE_BIT = 0;
    localparam int CTRL_SIGN_LSB = 12;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK_NEW = 16'h3001;
    localparam logic [15:0] CTRL_MASK_OLD = 16'h1001;

    // sign_mode_field encodings
    typedef enum logic [1:0] {
        SIGN_SIGNED = 2'b00,
        SIGN_UNSIGNED = 2'b01,
        SIGN_MIXED = 2'b10,
        SIGN_RESERVED = 2'b11
    } sign_mode_t;

    // result flag positions in the flag status register
    localparam int FLAG_OA = 0;
    localparam int FLAG_OB = 1;
    localparam int FLAG_OAB = 2;
    localparam int FLAG_SA = 3;
    localparam int FLAG_SB = 4;
    localparam int FLAG_SAB = 5;
    localparam int FLAG_W = 6;

    // interrupt event positions
    localparam int EV_OVF_A = 0;
    localparam int EV_OVF_B = 1;
    localparam int EV_SAT_A = 2;
    localparam int EV_SAT_B = 3;
    localparam int EV_ILLEGAL = 4;
    localparam int EV_W = 5;

    // apb register byte offsets
    localparam int APB_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_ACCUMULATOR_A_LO = 8'h10;
    localparam logic [7:0] ADDR_ACCUMULATOR_A_HI = 8'h14;
    localparam logic [7:0] ADDR_ACCUMULATOR_B_LO = 8'h18;
    localparam logic [7:0] ADDR_ACCUMULATOR_B_HI = 8'h1c;

    // decoded prefetch operation
    typedef struct packed {
        logic en;
        logic ptr_hi;
        logic offset;
        logic signed [3:0] modifier;
    } prefetch_op_t;

    // read view of working registers 4 to 12
    typedef struct packed {
        logic [15:0] w12;
        logic [15:0] w11;
        logic [15:0] w10;
        logic [15:0] w9;
        logic [15:0] w8;
        logic [15:0] w7;
        logic [15:0] w6;
        logic [15:0] w5;
        logic [15:0] w4;
    } wreg_bank_t;

    // one write request into the working register file
    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [15:0] data;
    } reg_write_t;

endpackage

`default_nettype wire

// ===== hdl/mac_product_unit.sv
// mac_product_unit: 16 x 16 multiplier giving a 40-bit product
// assumes operands already chosen; purely combinational
`default_nettype none

module mac_product_unit (
    input wire logic [15:0] first_multiplicand_in,
    input wire logic [15:0] second_multiplicand_in,
    input wire mac_pkg::sign_mode_t sign_mode_in,
    input wire logic frac_mode_in,
    output logic [39:0] product_out,
    output logic frac_sat_out
);

    logic first_signed;
    logic second_signed;
    logic signed [16:0] first_ext;
    logic signed [16:0] second_ext;
    logic signed [33:0] raw_product;
    logic signed [33:0] aligned_product;

    // operand signedness from the sign mode
    always_comb begin
        unique case (sign_mode_in)
            mac_pkg::SIGN_UNSIGNED: begin
                first_signed = 1'b0;
                second_signed = 1'b0;
            end
            mac_pkg::SIGN_MIXED: begin
                first_signed = 1'b1;
                second_signed = 1'b0;
            end
            default: begin
                first_signed = 1'b1;
                second_signed = 1'b1;
            end
        endcase
    end

    // extend, multiply, align and widen to accumulator size
    assign first_ext = {first_signed & first_multiplicand_in[15], first_multiplicand_in};
    assign second_ext = {second_signed & second_multiplicand_in[15], second_multiplicand_in};
    assign raw_product = first_ext * second_ext;
    assign aligned_product = frac_mode_in ? (raw_product <<< 1) : raw_product;
    assign product_out = {{6{aligned_product[33]}}, aligned_product};

    // minus one times minus one cannot be held as a 1.31 value
    assign frac_sat_out = frac_mode_in & first_signed & second_signed
        & (first_multiplicand_in == 16'h8000) & (second_multiplicand_in == 16'h8000);

endmodule

`default_nettype wire

// ===== hdl/mac_multiply_to_accumulator.sv
// mac_multiply_to_accumulator: execution of the multiply and square to
// accumulator instructions with parallel x and y operand prefetch.
// assumes one instruction per clock with its register read view,
// and data memory that answers in the next clock.
//
// Functional notes
// - Multiply: prefix 11000, zero bit 14, suffix 11.
// - Square: prefix 111100, zero bit 14, suffix 01.
// - Pair codes pick 4x5, 4x6, 4x7, 5x6, 5x7, 6x7.
// - Square multiplies one of registers 4 to 7 by itself.
// - The product, extended to 40 bits, replaces the accumulator.
// - The A bit picks accumulator a or b.
// - Control bit 0 set means integer, clear fractional.
// - Sign mode at 13:12, or bit 12 alone on older variants.
// - Each result updates overflow and saturate flags.
// - X prefetch reads via pointer 8 or 9, then adds -6..6.
// - Y prefetch reads via pointer 10 or 11, then adds -6..6.
// - Read at the old address, then write the new pointer.
// - Offset mode reads pointer 9 or 11 plus register 12, no writeback.
// - Fields x, y give destinations; i, j give operations.
// - The square is one word, one instruction per clock.
//
// Chosen here: the placing of the registers and register access over APB.
`default_nettype none

module mac_multiply_to_accumulator #(
    parameter bit NEW_SIGN_MODE = 1'b1
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // apb slave
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // instruction issue from the decoder
    input wire logic instr_valid_in,
    input wire logic [23:0] instr_word_in,
    input wire mac_pkg::wreg_bank_t wreg_in,
    // data memory read ports
    output logic mem_x_rd_out,
    output logic [15:0] mem_x_addr_out,
    input wire logic [15:0] mem_x_data_in,
    output logic mem_y_rd_out,
    output logic [15:0] mem_y_addr_out,
    input wire logic [15:0] mem_y_data_in,
    // register file write ports
    output mac_pkg::reg_write_t x_dest_wr_out,
    output mac_pkg::reg_write_t y_dest_wr_out,
    output mac_pkg::reg_write_t x_ptr_wr_out,
    output mac_pkg::reg_write_t y_ptr_wr_out,
    // results and status
    output logic [39:0] accumulator_a_out,
    output logic [39:0] accumulator_b_out,
    output logic [5:0] flags_out,
    output logic instr_done_out,
    output logic irq_out
);

    // decode of one i or j field into pointer choice and modifier
    function automatic mac_pkg::prefetch_op_t decode_prefetch(input logic [3:0] code);
        mac_pkg::prefetch_op_t op;
        op.en = (code != mac_pkg::PF_NONE);
        op.ptr_hi = code[3];
        op.offset = (code == mac_pkg::PF_REG_OFFSET);
        // 0..3 add 0,2,4,6; 5..7 add -6,-4,-2
        op.modifier = $signed({code[2], code[1:0], 1'b0});
        if (op.offset) begin
            op.modifier = 4'sd0;
        end
        return op;
    endfunction

    // read one of working registers 4 to 7
    function automatic logic [15:0] pick_wreg(input logic [1:0] idx, input mac_pkg::wreg_bank_t bank);
        logic [15:0] val;
        unique case (idx)
            2'd0: val = bank.w4;
            2'd1: val = bank.w5;
            2'd2: val = bank.w6;
            2'd3: val = bank.w7;
        endcase
        return val;
    endfunction

    // pointer value plus sign-extended modifier
    function automatic logic [15:0] add_modifier(input logic [15:0] ptr, input logic signed [3:0] modv);
        return ptr + {{12{modv[3]}}, modv};
    endfunction

    logic [15:0] ctrl_q;
    logic [4:0] irq_status_q;
    logic [4:0] irq_mask_q;
    logic [39:0] acc_a_q;
    logic [39:0] acc_b_q;
    logic oa_q, ob_q, sa_q, sb_q;

    // instruction decode
    logic is_mul, is_sqr, pair_ok, accepted, illegal;
    logic [1:0] first_idx, second_idx;
    logic acc_sel;
    mac_pkg::prefetch_op_t x_op, y_op;

    // pair field to register numbers; codes 3 and 7 are not pairs
    always_comb begin
        pair_ok = 1'b1;
        first_idx = 2'd0;
        second_idx = 2'd1;
        if (is_sqr) begin
            first_idx = instr_word_in[mac_pkg::SQR_REG_LSB +: 2];
            second_idx = instr_word_in[mac_pkg::SQR_REG_LSB +: 2];
        end else begin
            unique case (instr_word_in[mac_pkg::MUL_PAIR_LSB +: 3])
                3'd0: begin first_idx = 2'd0; second_idx = 2'd1; end
                3'd1: begin first_idx = 2'd0; second_idx = 2'd2; end
                3'd2: begin first_idx = 2'd0; second_idx = 2'd3; end
                3'd4: begin first_idx = 2'd1; second_idx = 2'd2; end
                3'd5: begin first_idx = 2'd1; second_idx = 2'd3; end
                3'd6: begin first_idx = 2'd2; second_idx = 2'd3; end
                default: pair_ok = 1'b0;
            endcase
        end
    end

    // opcode recognition
    assign is_mul = (instr_word_in[mac_pkg::MUL_PREFIX_LSB +: 5] == mac_pkg::MUL_PREFIX)
        & ~instr_word_in[mac_pkg::ZERO_BIT] & (instr_word_in[1:0] == mac_pkg::MUL_SUFFIX);
    assign is_sqr = (instr_word_in[mac_pkg::SQR_PREFIX_LSB +: 6] == mac_pkg::SQR_PREFIX)
        & ~instr_word_in[mac_pkg::ZERO_BIT] & (instr_word_in[1:0] == mac_pkg::SQR_SUFFIX);
    assign accepted = instr_valid_in & ((is_mul & pair_ok) | is_sqr);
    assign illegal = instr_valid_in & ~accepted;
    assign acc_sel = instr_word_in[mac_pkg::ACC_SEL_BIT];
    assign x_op = decode_prefetch(instr_word_in[mac_pkg::XOP_LSB +: 4]);
    assign y_op = decode_prefetch(instr_word_in[mac_pkg::YOP_LSB +: 4]);

    // multiply
    mac_pkg::sign_mode_t sign_mode;
    logic frac_mode, frac_sat;
    logic [39:0] product;
    logic prod_ovf;

    // older variants have a single sign bit and no mixed mode
    always_comb begin
        if (NEW_SIGN_MODE) begin
            sign_mode = mac_pkg::sign_mode_t'(ctrl_q[mac_pkg::CTRL_SIGN_LSB +: 2]);
        end else begin
            sign_mode = mac_pkg::sign_mode_t'({1'b0, ctrl_q[mac_pkg::CTRL_SIGN_LSB]});
        end
    end
    assign frac_mode = ~ctrl_q[mac_pkg::CTRL_INT_MODE_BIT];

    // operands from the read view, before prefetch writes
    mac_product_unit u_product (
        .first_multiplicand_in(pick_wreg(first_idx, wreg_in)),
        .second_multiplicand_in(pick_wreg(second_idx, wreg_in)),
        .sign_mode_in(sign_mode),
        .frac_mode_in(frac_mode),
        .product_out(product),
        .frac_sat_out(frac_sat)
    );

    // overflow into the guard bits: bits 39..31 not all equal
    assign prod_ovf = ~((&product[39:31]) | ~(|product[39:31]));

    // prefetch address generation
    logic [15:0] x_ptr, y_ptr, x_addr, y_addr;
    assign x_ptr = x_op.ptr_hi ? wreg_in.w9 : wreg_in.w8;
    assign y_ptr = y_op.ptr_hi ? wreg_in.w11 : wreg_in.w10;
    assign x_addr = x_op.offset ? wreg_in.w9 + wreg_in.w12 : x_ptr;
    assign y_addr = y_op.offset ? wreg_in.w11 + wreg_in.w12 : y_ptr;

    // apb decode
    logic apb_setup, apb_write;
    logic addr_mapped;
    logic [31:0] read_mux;
    logic [15:0] ctrl_mask;
    assign apb_setup = psel_in & ~penable_in;
    assign apb_write = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
    assign ctrl_mask = NEW_SIGN_MODE ? mac_pkg::CTRL_MASK_NEW : mac_pkg::CTRL_MASK_OLD;

    // read data and address map
    always_comb begin
        addr_mapped = 1'b1;
        read_mux = 32'h0000_0000;
        unique case (paddr_in)
            mac_pkg::ADDR_CTRL: read_mux = {16'h0000, ctrl_q};
            mac_pkg::ADDR_FLAGS: read_mux = {26'h000_0000, flags_out};
            mac_pkg::ADDR_IRQ_STATUS: read_mux = {27'h000_0000, irq_status_q};
            mac_pkg::ADDR_IRQ_MASK: read_mux = {27'h000_0000, irq_mask_q};
            mac_pkg::ADDR_ACCUMULATOR_A_LO: read_mux = acc_a_q[31:0];
            mac_pkg::ADDR_ACCUMULATOR_A_HI: read_mux = {{24{acc_a_q[39]}}, acc_a_q[39:32]};
            mac_pkg::ADDR_ACCUMULATOR_B_LO: read_mux = acc_b_q[31:0];
            mac_pkg::ADDR_ACCUMULATOR_B_HI: read_mux = {{24{acc_b_q[39]}}, acc_b_q[39:32]};
            default: addr_mapped = 1'b0;
        endcase
    end

    // answer in the access phase right after setup
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= apb_setup;
            pslverr_out <= apb_setup & ~addr_mapped;
            if (apb_setup) begin
                prdata_out <= pwrite_in ? 32'h0000_0000 : read_mux;
            end
        end
    end

    // core control and interrupt mask registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q <= mac_pkg::CTRL_RESET;
            irq_mask_q <= 5'h00;
        end else if (apb_write) begin
            if (paddr_in == mac_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata_in[15:0] & ctrl_mask;
            end
            if (paddr_in == mac_pkg::ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata_in[4:0];
            end
        end
    end

    // accumulators and result flags
    assign accumulator_a_out = acc_a_q;
    assign accumulator_b_out = acc_b_q;
    logic [31:0] clr_flags, clr_irq;
    logic ev_ovf_a, ev_ovf_b, ev_sat_a, ev_sat_b;
    logic oa_d, ob_d, sa_d, sb_d;
    assign clr_flags = (apb_write && paddr_in == mac_pkg::ADDR_FLAGS) ? pwdata_in : 32'h0000_0000;
    assign clr_irq = (apb_write && paddr_in == mac_pkg::ADDR_IRQ_STATUS) ? pwdata_in : 32'h0000_0000;
    assign ev_ovf_a = accepted & ~acc_sel & prod_ovf;
    assign ev_ovf_b = accepted & acc_sel & prod_ovf;
    assign ev_sat_a = accepted & ~acc_sel & frac_sat;
    assign ev_sat_b = accepted & acc_sel & frac_sat;

    // overflow follows the latest result; saturate is sticky, set beats clear
    always_comb begin
        oa_d = (accepted & ~acc_sel) ? prod_ovf : oa_q;
        ob_d = (accepted & acc_sel) ? prod_ovf : ob_q;
        sa_d = (sa_q & ~clr_flags[mac_pkg::FLAG_SA]) | ev_sat_a;
        sb_d = (sb_q & ~clr_flags[mac_pkg::FLAG_SB]) | ev_sat_b;
    end

    // accumulator replace, no add of the old value
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_a_q <= 40'h00_0000_0000;
            acc_b_q <= 40'h00_0000_0000;
        end else if (accepted) begin
            if (acc_sel) begin
                acc_b_q <= product;
            end else begin
                acc_a_q <= product;
            end
        end
    end

    // flag registers and their output copy
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            oa_q <= 1'b0;
            ob_q <= 1'b0;
            sa_q <= 1'b0;
            sb_q <= 1'b0;
            flags_out <= 6'h00;
        end else begin
            oa_q <= oa_d;
            ob_q <= ob_d;
            sa_q <= sa_d;
            sb_q <= sb_d;
            flags_out <= {sa_d | sb_d, sb_d, sa_d, oa_d | ob_d, ob_d, oa_d};
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_status_q <= 5'h00;
            irq_out <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~clr_irq[4:0]) | {illegal, ev_sat_b, ev_sat_a, ev_ovf_b, ev_ovf_a};
            irq_out <= |(((irq_status_q & ~clr_irq[4:0]) | {illegal, ev_sat_b, ev_sat_a, ev_ovf_b, ev_ovf_a})
                & irq_mask_q);
        end
    end

    // prefetch pipeline
    logic s1_valid;
    logic s1_x_en, s1_y_en, s1_x_wb, s1_y_wb;
    logic [1:0] s1_x_dest, s1_y_dest;
    logic s1_x_ptr_hi, s1_y_ptr_hi;
    logic [15:0] s1_x_ptr_new, s1_y_ptr_new;

    // stage one: read at the unmodified pointer
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_valid <= 1'b0;
            mem_x_rd_out <= 1'b0;
            mem_y_rd_out <= 1'b0;
            mem_x_addr_out <= 16'h0000;
            mem_y_addr_out <= 16'h0000;
            s1_x_en <= 1'b0;
            s1_y_en <= 1'b0;
            s1_x_wb <= 1'b0;
            s1_y_wb <= 1'b0;
            s1_x_dest <= 2'd0;
            s1_y_dest <= 2'd0;
            s1_x_ptr_hi <= 1'b0;
            s1_y_ptr_hi <= 1'b0;
            s1_x_ptr_new <= 16'h0000;
            s1_y_ptr_new <= 16'h0000;
        end else begin
            s1_valid <= accepted;
            mem_x_rd_out <= accepted & x_op.en;
            mem_y_rd_out <= accepted & y_op.en;
            mem_x_addr_out <= x_addr;
            mem_y_addr_out <= y_addr;
            s1_x_en <= accepted & x_op.en;
            s1_y_en <= accepted & y_op.en;
            s1_x_wb <= accepted & x_op.en & ~x_op.offset & (x_op.modifier != 4'sd0);
            s1_y_wb <= accepted & y_op.en & ~y_op.offset & (y_op.modifier != 4'sd0);
            s1_x_dest <= instr_word_in[mac_pkg::XD_LSB +: 2];
            s1_y_dest <= instr_word_in[mac_pkg::YD_LSB +: 2];
            s1_x_ptr_hi <= x_op.ptr_hi;
            s1_y_ptr_hi <= y_op.ptr_hi;
            s1_x_ptr_new <= add_modifier(x_ptr, x_op.modifier);
            s1_y_ptr_new <= add_modifier(y_ptr, y_op.modifier);
        end
    end

    // stage two: loaded words and new pointers
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            x_dest_wr_out <= '0;
            y_dest_wr_out <= '0;
            x_ptr_wr_out <= '0;
            y_ptr_wr_out <= '0;
            instr_done_out <= 1'b0;
        end else begin
            x_dest_wr_out <= '{we: s1_x_en, idx: mac_pkg::WREG_BASE + {2'b00, s1_x_dest}, data: mem_x_data_in};
            y_dest_wr_out <= '{we: s1_y_en, idx: mac_pkg::WREG_BASE + {2'b00, s1_y_dest}, data: mem_y_data_in};
            x_ptr_wr_out <= '{we: s1_x_wb, idx: mac_pkg::XPTR_BASE + {3'b000, s1_x_ptr_hi},
                data: s1_x_ptr_new};
            y_ptr_wr_out <= '{we: s1_y_wb, idx: mac_pkg::YPTR_BASE + {3'b000, s1_y_ptr_hi},
                data: s1_y_ptr_new};
            instr_done_out <= s1_valid;
        end
    end

endmodule

`default_nettype wire

// ===== tb/mac_data_mem.sv
// data memory model for the x and y prefetch read ports
// assumes read data is sampled at the edge after the request pulse
`default_nettype none
module mac_data_mem (
    input wire logic x_rd_in,
    input wire logic [15:0] x_addr_in,
    output logic [15:0] x_data_out,
    input wire logic y_rd_in,
    input wire logic [15:0] y_addr_in,
    output logic [15:0] y_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // data is the address xor 5a5a, inverted outside a read
    assign x_data_out = x_rd_in ? x_addr_in ^ 16'h5a5a : ~(x_addr_in ^ 16'h5a5a);
    assign y_data_out = y_rd_in ? y_addr_in ^ 16'h5a5a : ~(y_addr_in ^ 16'h5a5a);
endmodule
`default_nettype wire

// ===== tb/mac_multiply_to_accumulator_monitor.sv
// checker of decode, x prefetch and done timing
// assumes wreg_in held while a word is presented
`default_nettype none
module mac_monitor (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic instr_valid_in,
    input wire logic [23:0] instr_word_in,
    input wire mac_pkg::wreg_bank_t wreg_in,
    input wire logic mem_x_rd_out,
    input wire logic [15:0] mem_x_addr_out,
    input wire mac_pkg::reg_write_t x_dest_wr_out,
    input wire mac_pkg::reg_write_t x_ptr_wr_out,
    input wire logic [39:0] accumulator_b_out,
    input wire logic instr_done_out
);
    logic ok;
    logic [3:0] xi, xd;
    logic [15:0] xa, xm;
    // legal decode, x destination, address and modifier of the presented word
    assign xi = instr_word_in[9:6];
    assign xd = {2'h1, instr_word_in[13:12]};
    assign ok = instr_valid_in && !instr_word_in[14] && ((instr_word_in[23:19] == 5'h18 && instr_word_in[1:0] == 2'h3
        && instr_word_in[17:16] != 2'h3) || (instr_word_in[23:18] == 6'h3c && instr_word_in[1:0] == 2'h1));
    assign xa = xi == 4'hc ? wreg_in.w9 + wreg_in.w12 : (xi[3] ? wreg_in.w9 : wreg_in.w8);
    assign xm = {13'h0, xi[1:0], 1'h0} - (xi[2] ? 16'h0008 : 16'h0000);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    AST_DONE_LAT: assert property (ok |-> ##2 instr_done_out)
        else $error("done missing");
    AST_DONE_CAUSE: assert property (instr_done_out |-> $past(ok, 2))
        else $error("done without instruction");
    AST_X_READ: assert property (ok && xi != 4'h4 |=> mem_x_rd_out && mem_x_addr_out == $past(xa))
        else $error("x read address wrong");
    AST_X_IDLE: assert property (instr_valid_in && xi == 4'h4 |=> !mem_x_rd_out)
        else $error("x read without prefetch");
    AST_X_DEST: assert property (ok && xi != 4'h4 |-> ##2 x_dest_wr_out.we && x_dest_wr_out.idx == $past(xd, 2))
        else $error("x destination wrong");
    AST_X_PTR: assert property (ok && xi[1:0] != 2'h0 |-> ##2 x_ptr_wr_out.data == $past(xa + xm, 2))
        else $error("x pointer update wrong");
    AST_X_OFFSET: assert property (ok && xi == 4'hc |-> ##2 !x_ptr_wr_out.we)
        else $error("offset mode wrote pointer");
    AST_ACC_SEL: assert property (ok && !instr_word_in[15] |=> $stable(accumulator_b_out))
        else $error("accumulator b changed");
    cover property (ok && instr_word_in[1:0] == 2'h1);
    cover property (ok && xi == 4'hc);
    cover property (ok && instr_word_in[15]);
endmodule
bind mac_multiply_to_accumulator mac_monitor u_mac_monitor (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in), .wreg_in(wreg_in), .mem_x_rd_out(mem_x_rd_out),
    .mem_x_addr_out(mem_x_addr_out), .x_dest_wr_out(x_dest_wr_out), .x_ptr_wr_out(x_ptr_wr_out),
    .accumulator_b_out(accumulator_b_out), .instr_done_out(instr_done_out));
`default_nettype wire

// ===== tb/test_mac_multiply_to_accumulator.sv
// testbench: apb access, multiply and square with prefetch, sign modes, interrupt
// assumes the data memory model returns the address xor 5a5a
`default_nettype none
module test_mac_multiply_to_accumulator;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, valid = 1'h0, se;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [23:0] word = 24'h00_0000;
    mac_pkg::wreg_bank_t wreg = '0;
    logic pready, pslverr, xrd, yrd, done, irq;
    logic [15:0] xa, ya, xd, yd;
    mac_pkg::reg_write_t xw, yw, xp, yp, xwc, ywc, xpc, ypc;
    logic [39:0] accumulator_a, accumulator_b;
    logic [5:0] flags;
    logic [3:0] cd[12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'h2, 4'h2};
    int ct[12] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 32'h1001, 32'h2001};
    int ex[12] = '{15, 21, -3, 35, -5, -7, 9, 25, 49, 1, 32'h2_fffd, 32'h2_fffd};
    int errors = 0, n_compared = 0;
    always #50 sys_clk = ~sys_clk;
    mac_multiply_to_accumulator u_mac_multiply_to_accumulator (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .instr_valid_in(valid),
        .instr_word_in(word), .wreg_in(wreg), .mem_x_rd_out(xrd), .mem_x_addr_out(xa), .mem_x_data_in(xd),
        .mem_y_rd_out(yrd), .mem_y_addr_out(ya), .mem_y_data_in(yd), .x_dest_wr_out(xw), .y_dest_wr_out(yw),
        .x_ptr_wr_out(xp), .y_ptr_wr_out(yp), .accumulator_a_out(accumulator_a), .accumulator_b_out(accumulator_b),
        .flags_out(flags), .instr_done_out(done), .irq_out(irq));
    mac_data_mem u_mac_data_mem (.x_rd_in(xrd), .x_addr_in(xa), .x_data_out(xd), .y_rd_in(yrd), .y_addr_in(ya),
        .y_data_out(yd));
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // apb setup, then access held until pready is high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [23:0] op(input logic sq, input logic [2:0] m, input logic a, input logic [11:0] pf);
        return sq ? {6'h3c, m[1:0], a, 1'h0, pf, 2'h1} : {5'h18, m, a, 1'h0, pf, 2'h3};
    endfunction
    // present one word, capture the write pulses two edges later
    task automatic issue(input logic [23:0] w);
        @(posedge sys_clk);
        valid <= 1'h1;
        word <= w;
        @(posedge sys_clk);
        valid <= 1'h0;
        repeat (2) @(posedge sys_clk);
        {xwc, ywc, xpc, ypc} = {xw, yw, xp, yp};
        @(posedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100_000;
        errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'h1;
        apb(1'h0, 8'h00, 32'h0000_0000);
        check(rd, 40'h0);
        {wreg.w4, wreg.w5} <= 32'h8000_8000;
        issue(op(1'h0, 3'h0, 1'h0, 12'h044));
        check(accumulator_a, 40'h00_8000_0000);
        check(flags, 40'h2d);
        {wreg.w4, wreg.w5, wreg.w8, wreg.w10} <= 64'hc000_9000_1780_2400;
        issue(op(1'h0, 3'h0, 1'h0, 12'hb17));
        check(accumulator_a, 40'h00_3800_0000);
        check(xwc, 40'h16_4dda);
        check(xpc, 40'h18_1782);
        check(ywc, 40'h17_7e5a);
        check(ypc, 40'h1a_23fe);
        {wreg.w4, wreg.w9, wreg.w10, wreg.w12} <= 64'he228_1700_1b00_ff00;
        issue(op(1'h1, 3'h0, 1'h1, 12'h1c1));
        check(accumulator_b, 40'h00_06f5_4c80);
        check(xwc, 40'h14_4c5a);
        check(xpc[20], 40'h0);
        check(ypc, 40'h1a_1b02);
        {wreg.w4, wreg.w5, wreg.w6, wreg.w7} <= 64'h0003_0005_0007_ffff;
        for (int k = 0; k < 12; k++) begin
            apb(1'h1, 8'h00, ct[k]);
            issue(op(cd[k][3], cd[k][2:0], 1'h0, 12'h044));
            check(accumulator_a, 40'(ex[k]));
        end
        apb(1'h1, 8'h0c, 32'h0000_0010);
        issue(24'hff_ffff);
        check(irq, 40'h1);
        apb(1'h1, 8'h08, 32'h0000_0010);
        repeat (2) @(posedge sys_clk);
        check(irq, 40'h0);
        apb(1'h1, 8'h0c, 32'h0000_0000);
        issue(24'hff_ffff);
        check(irq, 40'h0);
        apb(1'h0, 8'h08, 32'h0000_0000);
        check(rd[4], 40'h1);
        apb(1'h0, 8'h40, 32'h0000_0000);
        check(se, 40'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
